// ===== src/pipe_ctl_pkg.sv
// Purpose: Shared constants and types for the eleven-stage pipeline control
// Assumes: One core clock; stage numbers count from one at the first fetch stage
// Notes: Stall counts are core cycles
package pipe_ctl_pkg;
  // ----------------------------------------------------------------
  // Stage layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_STAGES = 11;
  localparam int unsigned STG_FETCH_FIRST = 1;
  localparam int unsigned STG_FETCH_LAST = 4;
  localparam int unsigned STG_DECODE = 5;
  localparam int unsigned STG_ADDR_GEN = 6;
  localparam int unsigned STG_ACCESS_FIRST = 7;
  localparam int unsigned STG_ACCESS_LAST = 10;
  localparam int unsigned STG_COMPUTE_FIRST = 10;
  localparam int unsigned STG_COMPUTE_LAST = 11;
  localparam int unsigned STG_FLOW = 7;
  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned REG_IDX_W = 4;
  localparam int unsigned CC_ENTRIES = 32;
  localparam int unsigned CC_IDX_W = 5;
  localparam int unsigned INSN_W = 48;
  localparam int unsigned BLOCK_W = 2;
  localparam int unsigned CNT_W = 6;
  // ----------------------------------------------------------------
  // Stall counts
  // ----------------------------------------------------------------
  localparam logic [5:0] CORE_REG_STALL_MAX = 6'h04;
  localparam logic [5:0] FABRIC_MIN = 6'h26;
  localparam logic [5:0] FABRIC_MAX = 6'h3c;
  localparam logic [5:0] BLOCK_CONFLICT_STALL = 6'h01;
  localparam logic [5:0] DUAL_FWD_NEAR_STALL = 6'h02;
  localparam logic [5:0] DUAL_FWD_FAR_STALL = 6'h01;
  localparam logic [5:0] INDEX_LOAD_STALL = 6'h04;
  localparam logic [5:0] DOUBLE_PREC_STALL = 6'h01;
  localparam logic [3:0] INDEX_LOAD_LATENCY = 4'h4;

  // Source of the active stall
  typedef enum logic [2:0] {
    STALL_NONE,
    STALL_CORE_REG,
    STALL_FABRIC,
    STALL_HAZARD
  } stall_src_type;
endpackage : pipe_ctl_pkg

// ===== src/conflict_cache_if.sv
// Purpose: Carrier between pipeline control and the conflict cache
// Assumes: Same clock as the control
// Notes: Lookup is combinational, allocation is one cycle
`timescale 1ns/1ps
interface conflict_cache_if;
  logic [31:0] lookup_addr;
  logic lookup_hit;
  logic [47:0] lookup_insn;
  logic alloc_en;
  logic [31:0] alloc_addr;
  logic [47:0] alloc_insn;
  modport ctl (output lookup_addr, input lookup_hit, input lookup_insn,
               output alloc_en, output alloc_addr, output alloc_insn);
  modport cache (input lookup_addr, output lookup_hit, output lookup_insn,
                 input alloc_en, input alloc_addr, input alloc_insn);
endinterface : conflict_cache_if

// ===== src/conflict_cache.sv
// Purpose: Thirty-two entry conflict cache, round-robin replacement
// Assumes: Allocation only requested on internal bus conflicts
// Notes: Fully associative; a duplicate allocation refreshes nothing extra
`timescale 1ns/1ps
module conflict_cache (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control side
  conflict_cache_if.cache cc
);
  logic [31:0] tag_ff [pipe_ctl_pkg::CC_ENTRIES];
  logic [47:0] data_ff [pipe_ctl_pkg::CC_ENTRIES];
  logic [pipe_ctl_pkg::CC_ENTRIES-1:0] valid_ff;
  logic [4:0] victim_ff;
  logic [4:0] hit_idx;
  logic hit_any;

  // Associative search across all entries
  always_comb begin
    hit_any = 1'b0;
    hit_idx = 5'h00;
    for (int i = 0; i < pipe_ctl_pkg::CC_ENTRIES; i++) begin
      if (valid_ff[i] && tag_ff[i] == cc.lookup_addr) begin
        hit_any = 1'b1;
        hit_idx = 5'(i);
      end
    end
  end
  assign cc.lookup_hit = hit_any;
  assign cc.lookup_insn = data_ff[hit_idx];

  // Valid bits and replacement pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= '0;
      victim_ff <= 5'h00;
    end else if (cc.alloc_en) begin
      valid_ff[victim_ff] <= 1'b1;
      victim_ff <= victim_ff + 5'h01;
    end
  end

  // Entry storage has no reset; valid bits guard it
  always_ff @(posedge clk) begin
    if (cc.alloc_en) begin
      tag_ff[victim_ff] <= cc.alloc_addr;
      data_ff[victim_ff] <= cc.alloc_insn;
    end
  end
endmodule : conflict_cache

// ===== src/pipe_ctl.sv
// Purpose: Interlock, stall and flush control for an eleven-stage core pipeline
// Assumes: Hazard flags arrive from decode on the core clock; no software registers
// Notes: Stall counts are loaded once and counted down; flush beats stall
// Notes on behaviour
// [RULE_01] Core-mapped register stalls never exceed four
// [RULE_02] System-mapped access lasts 38 to 60 cycles
// [RULE_03] Conflict cache holds thirty-two entries
// [RULE_04] Cache fills only on internal bus conflict
// [RULE_05] Eleven stages: fetch, decode, address, access, compute
// [RULE_06] Address stage adds modifier to index
// [RULE_07] Change of flow resolved at stage seven
// [RULE_08] Compute starts stage ten, no load stall
// [RULE_09] Fetch phase plus up to two data accesses
// [RULE_10] Same-block data accesses stall one cycle
// [RULE_11] Register and flag readers interlock until ready
// [RULE_12] Data access on program bus stalls fetch
// [RULE_13] Index load-to-use stalls address stage
// [RULE_14] Dual multiplier forwarding adds stall cycles
// [RULE_15] Legacy latency and double precision stall
// [RULE_16] Branch flushes all younger instructions
// [RULE_17] Stall holds earlier stages, bubble advances
`timescale 1ns/1ps
module pipe_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fetch side
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic [47:0] fetch_insn,
  // Decode side hazard flags for the instruction in decode
  input wire logic dec_valid,
  input wire logic dec_reads_busy_reg,
  input wire logic dec_uses_index,
  input wire logic [3:0] dec_index_sel,
  input wire logic dec_loads_index,
  input wire logic dec_dual_fwd_near,
  input wire logic dec_dual_fwd_far,
  input wire logic dec_legacy_latency,
  input wire logic dec_double_prec,
  input wire logic dec_core_reg,
  input wire logic [2:0] dec_core_reg_stall,
  input wire logic dec_sys_reg,
  // Address generator operands
  input wire logic [31:0] index_value,
  input wire logic [31:0] modifier_value,
  // Data access requests in the first access stage
  input wire logic acc_pm_valid,
  input wire logic [1:0] acc_pm_block,
  input wire logic acc_dm_valid,
  input wire logic [1:0] acc_dm_block,
  // System fabric completion
  input wire logic fabric_done,
  // Change of flow at the first access stage
  input wire logic flow_taken,
  input wire logic [31:0] flow_target,
  // Stage control outputs
  output logic [10:0] stage_valid,
  output logic [10:0] stage_hold,
  output logic stall,
  output logic flush,
  output logic [31:0] fetch_pc,
  output logic [31:0] data_addr,
  output logic cc_supply,
  output logic [47:0] cc_insn
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [10:0] valid_ff;
  logic [10:0] nxt_valid;
  logic [10:0] hold_ff;
  logic [10:0] nxt_hold;
  logic [5:0] stall_cnt_ff;
  logic [5:0] nxt_stall_cnt;
  logic [5:0] fab_cnt_ff;
  logic [5:0] nxt_fab_cnt;
  logic fab_busy_ff;
  logic [3:0] idx_busy_ff [16];
  logic stall_ff;
  logic flush_ff;
  logic [31:0] pc_ff;
  logic [31:0] daddr_ff;
  logic cc_supply_ff;
  logic [47:0] cc_insn_ff;
  pipe_ctl_pkg::stall_src_type src_ff;

  conflict_cache_if cc_bus ();

  // [RULE_03] Thirty-two entry store
  conflict_cache u_cache (
    .clk(clk),
    .rst_n(rst_n),
    .cc(cc_bus.cache)
  );

  function automatic logic [5:0] max6(input logic [5:0] a, input logic [5:0] b);
    max6 = (a > b) ? a : b;
  endfunction : max6

  // ----------------------------------------------------------------
  // Hazard decode
  // ----------------------------------------------------------------
  // [RULE_10] Same block conflict
  wire block_conflict = acc_pm_valid && acc_dm_valid && (acc_pm_block == acc_dm_block);
  // [RULE_12] Program bus shared with fetch
  wire pm_struct = acc_pm_valid && fetch_req;
  // [RULE_04] Conflict path looks in the cache first
  wire pm_cc_hit = pm_struct && cc_bus.lookup_hit;
  wire pm_stall = pm_struct && !cc_bus.lookup_hit;
  // [RULE_13] Index still being loaded
  wire idx_pending = dec_valid && dec_uses_index && (idx_busy_ff[dec_index_sel] != 4'h0);
  // [RULE_14] Dual forwarding penalty
  wire [5:0] fwd_stall = !dec_valid ? 6'h00 :
    dec_dual_fwd_near ? pipe_ctl_pkg::DUAL_FWD_NEAR_STALL :
    dec_dual_fwd_far ? pipe_ctl_pkg::DUAL_FWD_FAR_STALL : 6'h00;
  // [RULE_15] Legacy latency and double precision
  wire [5:0] misc_stall = (dec_valid && (dec_legacy_latency || dec_double_prec)) ?
    pipe_ctl_pkg::DOUBLE_PREC_STALL : 6'h00;
  // [RULE_01] Core register stall clipped to four
  wire [5:0] core_req = {3'h0, dec_core_reg_stall};
  wire [5:0] core_stall = (dec_valid && dec_core_reg) ?
    ((core_req > pipe_ctl_pkg::CORE_REG_STALL_MAX) ? pipe_ctl_pkg::CORE_REG_STALL_MAX : core_req) : 6'h00;
  wire [5:0] blk_stall = block_conflict ? pipe_ctl_pkg::BLOCK_CONFLICT_STALL : 6'h00;
  wire [5:0] new_cnt = max6(max6(fwd_stall, misc_stall), max6(core_stall, blk_stall));
  // A decode slot that a change of flow flushes never starts a fabric access
  wire fab_start = dec_valid && dec_sys_reg && !fab_busy_ff && !flow_taken;
  // [RULE_02] Fabric completes within the window
  wire fab_end = fab_busy_ff && ((fabric_done && fab_cnt_ff >= pipe_ctl_pkg::FABRIC_MIN)
    || fab_cnt_ff >= pipe_ctl_pkg::FABRIC_MAX);
  wire counting = stall_cnt_ff != 6'h00;
  // [RULE_11] Full interlock on busy registers
  wire stall_now = !flow_taken && (counting || dec_reads_busy_reg || idx_pending || pm_stall
    || (new_cnt != 6'h00) || fab_start || (fab_busy_ff && !fab_end));

  // ----------------------------------------------------------------
  // Stage advance
  // ----------------------------------------------------------------
  // [RULE_05] Stage 5 holds the decode hazard point
  localparam int unsigned HOLD_STAGE = pipe_ctl_pkg::STG_DECODE;
  always_comb begin
    nxt_valid = valid_ff;
    nxt_hold = '0;
    if (flow_taken) begin
      // [RULE_16] Flush younger stages 1 to 7
      nxt_valid = {valid_ff[9:pipe_ctl_pkg::STG_FLOW-1], 7'h00};
      nxt_valid[0] = 1'b1;
    end else if (stall_now) begin
      // [RULE_17] Hold stages 1..5, bubble into 6
      nxt_hold = 11'h01f;
      nxt_valid = {valid_ff[9:HOLD_STAGE], 1'b0, valid_ff[HOLD_STAGE-1:0]};
    end else begin
      nxt_valid = {valid_ff[9:0], fetch_req};
    end
  end

  // Stall counter: counts down while nonzero, otherwise new hazards load
  always_comb begin
    nxt_stall_cnt = stall_cnt_ff;
    if (flow_taken) begin
      nxt_stall_cnt = 6'h00;
    end else if (counting) begin
      nxt_stall_cnt = stall_cnt_ff - 6'h01;
    end else if (new_cnt != 6'h00) begin
      nxt_stall_cnt = new_cnt - 6'h01;
    end
  end

  assign nxt_fab_cnt = fab_start ? 6'h01 : (fab_busy_ff ? fab_cnt_ff + 6'h01 : 6'h00);

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= '0;
      hold_ff <= '0;
      stall_cnt_ff <= 6'h00;
      stall_ff <= 1'b0;
      flush_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
      hold_ff <= nxt_hold;
      stall_cnt_ff <= nxt_stall_cnt;
      stall_ff <= stall_now;
      flush_ff <= flow_taken;
    end
  end

  // Fabric access tracker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fab_busy_ff <= 1'b0;
      fab_cnt_ff <= 6'h00;
      src_ff <= pipe_ctl_pkg::STALL_NONE;
    end else begin
      fab_busy_ff <= fab_start || (fab_busy_ff && !fab_end && !flow_taken);
      fab_cnt_ff <= nxt_fab_cnt;
      src_ff <= fab_busy_ff ? pipe_ctl_pkg::STALL_FABRIC :
        (core_stall != 6'h00) ? pipe_ctl_pkg::STALL_CORE_REG :
        stall_now ? pipe_ctl_pkg::STALL_HAZARD : pipe_ctl_pkg::STALL_NONE;
    end
  end

  // [RULE_13] Index load scoreboard, four cycle load-to-use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) idx_busy_ff[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (dec_valid && dec_loads_index && !stall_now && dec_index_sel == 4'(i)) begin
          idx_busy_ff[i] <= pipe_ctl_pkg::INDEX_LOAD_LATENCY;
        end else if (idx_busy_ff[i] != 4'h0) begin
          idx_busy_ff[i] <= idx_busy_ff[i] - 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Addresses, fetch target and conflict cache
  // ----------------------------------------------------------------
  // [RULE_06] Index plus modifier in one stage
  wire [31:0] dag_sum = index_value + modifier_value;
  // [RULE_09] Fetch phase and data phase share the program bus
  assign cc_bus.lookup_addr = fetch_addr;
  // [RULE_04] Allocate on bus conflict only
  assign cc_bus.alloc_en = pm_stall;
  assign cc_bus.alloc_addr = fetch_addr;
  assign cc_bus.alloc_insn = fetch_insn;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= 32'h0000_0000;
      daddr_ff <= 32'h0000_0000;
      cc_supply_ff <= 1'b0;
      cc_insn_ff <= 48'h0000_0000_0000;
    end else begin
      // [RULE_07] Target enters first fetch stage
      pc_ff <= flow_taken ? flow_target : fetch_addr;
      if (!stall_now) begin
        daddr_ff <= dag_sum;
      end
      cc_supply_ff <= pm_cc_hit && !flow_taken;
      cc_insn_ff <= cc_bus.lookup_insn;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // [RULE_08] Stage 10 and 11 carry compute with no load stall
  assign stage_valid = valid_ff;
  assign stage_hold = hold_ff;
  assign stall = stall_ff;
  assign flush = flush_ff;
  assign fetch_pc = pc_ff;
  assign data_addr = daddr_ff;
  assign cc_supply = cc_supply_ff;
  assign cc_insn = cc_insn_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A flush overrides every stall, so the stall checks leave flow_taken out
  // Stall checks look at the registered outputs one cycle after the cause
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_core_stall_max: assert property (stall_cnt_ff < pipe_ctl_pkg::CORE_REG_STALL_MAX) // [RULE_01]
    else $error("core register stall too long");
  a_fabric_window: assert property (fab_busy_ff |-> fab_cnt_ff <= pipe_ctl_pkg::FABRIC_MAX) // [RULE_02]
    else $error("fabric access exceeds window");
  a_cache_alloc_only: assert property (cc_bus.alloc_en |-> acc_pm_valid && fetch_req) // [RULE_04]
    else $error("cache allocated without conflict");
  a_flow_flush: assert property (flow_taken |=> flush && stage_valid[6:1] == 6'h00) // [RULE_16]
    else $error("younger stages not flushed");
  a_flow_target: assert property (flow_taken |=> fetch_pc == $past(flow_target)) // [RULE_07]
    else $error("target not fetched");
  a_block_stall: assert property (block_conflict && !flow_taken |=> stall) // [RULE_10]
    else $error("block conflict without stall");
  a_busy_interlock: assert property (dec_reads_busy_reg && !flow_taken |=> stall && stage_hold[4]) // [RULE_11]
    else $error("busy register read not stalled");
  a_bubble_insert: assert property (stall_now && !flow_taken |=> !stage_valid[5]) // [RULE_17]
    else $error("bubble missing after stall");
  a_dual_fwd: assert property (dec_valid && dec_dual_fwd_near && !counting && !flow_taken
    |=> stall_cnt_ff == 6'h01) // [RULE_14]
    else $error("dual forwarding stall wrong");
  a_pm_struct: assert property (pm_stall && !flow_taken |=> stall && stage_hold[4]) // [RULE_12]
    else $error("program bus conflict not stalled");
  a_index_stall: assert property (idx_pending && !flow_taken |=> stall && !stage_valid[5]) // [RULE_13]
    else $error("index load-to-use not stalled");
  a_addr_sum: assert property (!stall_now |=> data_addr == 32'($past(index_value) + $past(modifier_value))) // [RULE_06]
    else $error("data address not index plus modifier");
  a_fabric_min: assert property (fab_busy_ff && !flow_taken && (fab_cnt_ff < pipe_ctl_pkg::FABRIC_MIN) |=> stall) // [RULE_02]
    else $error("fabric access ended too early");
  a_flow_clears: assert property (flow_taken |=> stall_cnt_ff == 6'h00 && !fab_busy_ff) // [RULE_16]
    else $error("counters not cleared by flush");
  // Main scenarios the bench is expected to reach
  c_flush: cover property (flow_taken ##1 flush);
  c_fabric: cover property (fab_start ##[38:60] fab_end);
  c_cache_hit: cover property (pm_cc_hit);
  c_index_stall: cover property (idx_pending);
  c_core_max: cover property (core_stall == pipe_ctl_pkg::CORE_REG_STALL_MAX);
endmodule : pipe_ctl

// ===== verification/fabric_model.sv
// Purpose: Behavioural system fabric that answers system-mapped register accesses
// Assumes: One access at a time, started by a single-cycle strobe
// Notes: A delay of zero never answers, so the control's own upper bound is exercised
`timescale 1ns/1ps
module fabric_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request side
  input wire logic start,
  input wire logic [7:0] delay,
  // Answer side
  output logic fabric_done
);
  logic [7:0] left_ff;

  // Count down the chosen latency, then pulse once; a new start while busy is ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_ff <= 8'h00;
      fabric_done <= 1'b0;
    end else begin
      fabric_done <= (left_ff == 8'h01);
      if (start && left_ff == 8'h00) begin
        left_ff <= delay;
      end else if (left_ff != 8'h00) begin
        left_ff <= left_ff - 8'h01;
      end
    end
  end
endmodule : fabric_model

// ===== verification/tb.sv
// Purpose: Self-checking bench for the pipeline interlock and flush control
// Assumes: Stall, flush and stage outputs answer one cycle after their cause
// Notes: Stall run lengths are scored from a queue of expected ranges
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, fetch_req, dec_valid, dec_reads_busy_reg, dec_uses_index, dec_loads_index;
  logic dec_dual_fwd_near, dec_dual_fwd_far, dec_legacy_latency, dec_double_prec;
  logic dec_core_reg, dec_sys_reg, acc_pm_valid, acc_dm_valid, fabric_done, flow_taken;
  logic [31:0] fetch_addr, index_value, modifier_value, flow_target, fetch_pc, data_addr;
  logic [47:0] fetch_insn, cc_insn;
  logic [3:0] dec_index_sel, hz;
  logic [2:0] dec_core_reg_stall;
  logic [1:0] acc_pm_block, acc_dm_block;
  logic [10:0] stage_valid, stage_hold;
  logic stall, flush, cc_supply;
  logic [7:0] fab_delay;
  int fail_count, total_checks, cycles, run, seed, lo, hi;
  int exp_lo[$];
  int exp_hi[$];

  pipe_ctl dut_u (.clk, .rst_n, .fetch_req, .fetch_addr, .fetch_insn, .dec_valid, .dec_reads_busy_reg,
    .dec_uses_index, .dec_index_sel, .dec_loads_index, .dec_dual_fwd_near, .dec_dual_fwd_far,
    .dec_legacy_latency, .dec_double_prec, .dec_core_reg, .dec_core_reg_stall, .dec_sys_reg,
    .index_value, .modifier_value, .acc_pm_valid, .acc_pm_block, .acc_dm_valid, .acc_dm_block,
    .fabric_done, .flow_taken, .flow_target, .stage_valid, .stage_hold, .stall, .flush, .fetch_pc,
    .data_addr, .cc_supply, .cc_insn);

  fabric_model fab_u (.clk, .rst_n, .start(dec_sys_reg & dec_valid), .delay(fab_delay), .fabric_done);

  // Core clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic check(string what, logic [47:0] seen, logic [47:0] expv);
    total_checks++;
    if (seen !== expv) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Driving helpers
  // ----------------------------------------------------------------
  task automatic quiet;
    {fetch_req, dec_valid, dec_reads_busy_reg, dec_uses_index, dec_loads_index} <= '0;
    {dec_dual_fwd_near, dec_dual_fwd_far, dec_legacy_latency, dec_double_prec} <= '0;
    {dec_core_reg, dec_sys_reg, acc_pm_valid, acc_dm_valid, flow_taken} <= '0;
  endtask : quiet

  // Hold the request one cycle, then look at the answer mid-cycle
  task automatic go;
    @(posedge clk);
    quiet();
    @(negedge clk);
  endtask : go

  // Wait for the stall to end and its note to be scored
  task automatic drain;
    int n;
    n = 0;
    while ((stall !== 1'b0 || exp_lo.size() != 0) && n < 100) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
  endtask : drain

  task automatic expect_run(int a, int b);
    exp_lo.push_back(a);
    exp_hi.push_back(b);
  endtask : expect_run

  // Watch stall runs; an unannounced stall is scored against zero
  always @(posedge clk) begin
    if (rst_n !== 1'b1) begin
      run = 0;
    end else if (stall === 1'b1) begin
      run++;
    end else if (run > 0) begin
      if (exp_lo.size() == 0) begin
        check("stall_run_unexpected", 48'(run), 48'h0);
      end else begin
        lo = exp_lo.pop_front();
        hi = exp_hi.pop_front();
        check("stall_run", 48'(run), (run >= lo && run <= hi) ? 48'(run) : 48'(lo));
      end
      run = 0;
    end
  end

  // Hang guard, well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h796e552b;
    rst_n = 1'b0;
    quiet();
    {dec_index_sel, dec_core_reg_stall, acc_pm_block, acc_dm_block, fab_delay} <= '0;
    {fetch_addr, fetch_insn, index_value, modifier_value, flow_target} <= '0;
    repeat (2) @(posedge clk);
    check("stall_in_reset", stall, 1'b0);
    check("stage_valid_in_reset", stage_valid, 11'h000);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
    for (int b = 0; b < 8; b++) begin
      @(posedge clk);
      {acc_pm_valid, acc_dm_valid} <= 2'h3;
      acc_pm_block <= b[1:0];
      acc_dm_block <= (b < 4) ? b[1:0] : b[1:0] + 2'h1;
      if (b < 4) expect_run(1, 1);
      go();
      check("stall_hold", stage_hold, (b < 4) ? 11'h01f : 11'h000);
      drain();
    end
    for (int n = 1; n < 8; n++) begin
      @(posedge clk);
      {dec_valid, dec_core_reg} <= 2'h3;
      dec_core_reg_stall <= n[2:0];
      expect_run((n > 4) ? 4 : n, (n > 4) ? 4 : n);
      go();
      drain();
    end
    for (int k = 0; k < 5; k++) begin
      hz = (k < 4) ? (4'h8 >> k) : 4'h9;
      @(posedge clk);
      dec_valid <= 1'b1;
      {dec_dual_fwd_near, dec_dual_fwd_far, dec_legacy_latency, dec_double_prec} <= hz;
      expect_run(hz[3] ? 2 : 1, hz[3] ? 2 : 1);
      go();
      drain();
    end
    // interlock while the operand is busy
    @(posedge clk);
    {dec_valid, dec_reads_busy_reg} <= 2'h3;
    expect_run(3, 4);
    repeat (2) @(posedge clk);
    go();
    drain();
    // index load then use, same and other register
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      {dec_valid, dec_loads_index} <= 2'h3;
      dec_index_sel <= 4'h5;
      @(posedge clk);
      {dec_loads_index, dec_uses_index} <= 2'h1;
      dec_index_sel <= 4'h5 + s[3:0];
      if (s == 0) expect_run(1, 4);
      go();
      drain();
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      index_value <= $random(seed);
      modifier_value <= $random(seed);
      go();
      check("data_addr", data_addr, 32'(index_value + modifier_value));
    end
    // change of flow flushes younger stages
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      flow_taken <= 1'b1;
      flow_target <= $random(seed);
      go();
      check("flush", flush, 1'b1);
      check("fetch_pc", fetch_pc, flow_target);
      check("stage_valid", stage_valid[6:0], 7'h01);
      @(negedge clk);
      check("flush_end", flush, 1'b0);
    end
    // conflict cache fills on program-bus conflict only
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      if (k != 2) begin
        {fetch_req, acc_pm_valid} <= 2'h3;
      end else begin
        fetch_req <= 1'b1;
      end
      if (k == 0 || k == 2) begin
        fetch_addr <= $random(seed);
        fetch_insn <= {$random(seed), $random(seed)};
      end
      if (k == 0 || k == 3) expect_run(1, 1);
      go();
      if (k == 1) check("cc_insn", cc_insn, fetch_insn);
      check("cc_supply", cc_supply, 48'(k == 1));
      drain();
    end
    // fabric access bounded whether answered early, mid or never
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {dec_valid, dec_sys_reg} <= 2'h3;
      fab_delay <= (k == 0) ? 8'h05 : (k == 1) ? 8'h2d : 8'h00;
      expect_run(38, 60);
      go();
      drain();
    end
    wrap_up();
  end
endmodule : tb
